//--- include/ic_defs.svh
// register offsets, field positions, reset values and timing counts
// for the two-wire bus control block; assumes a 125 MHz system clock
//
// Functional notes
// - control bit 7 enables module; clear acts as soft reset, registers stay accessible.
// - other control bits do nothing while module enable is clear.
// - enabled mid-transfer, slave logic waits for the next start condition.
// - master enabled mid-transfer may corrupt bus; recovers via arbitration loss.
// - interrupt output needs interrupt enable bit 6 and pending flag both set.
// - clearing interrupt enable only masks output; pending flags stay.
// - master select bit 5 resets zero; rising write issues START, enters master.
// - master select falling write issues STOP, returns to slave mode; code issues STOP only when the write lands in ST_HOLD, between bytes.
// - arbitration loss clears master select without driving STOP.
// - control bit 4 selects direction: one transmit, zero receive.
// - control bit 3 sets acknowledge level only while receiving.
// - ack control zero drives acknowledge on 9th clock; one leaves SDA high.
// - writing one to bit 2 issues repeated START only while bus master.
// - repeat start bit always reads as zero.
// - repeat start requested while not master results in arbitration loss.
// - every arbitration loss sets lost flag; software clears it writing zero.
`ifndef IC_DEFS_SVH
`define IC_DEFS_SVH

// byte addresses on the register bus
`define IC_ADDR_OWN 8'h00
`define IC_ADDR_CTRL 8'h04
`define IC_ADDR_STAT 8'h08
`define IC_ADDR_DATA 8'h0C
`define IC_ADDR_EVT 8'h10
`define IC_ADDR_MASK 8'h14

// control field positions
`define IC_CB_EN 7
`define IC_CB_IE 6
`define IC_CB_MS 5
`define IC_CB_DIR 4
`define IC_CB_ACK 3
`define IC_CB_RS 2

// status field positions
`define IC_SB_TC 7
`define IC_SB_AAS 6
`define IC_SB_BUSY 5
`define IC_SB_AL 4

// event bit positions and width
`define IC_EV_DONE 0
`define IC_EV_AL 1
`define IC_EV_AAS 2
`define IC_EV_W 3

// reset values
`define IC_CTRL_RST 8'h00
`define IC_OWN_RST 8'h00
`define IC_EVT_RST 3'h0

// bus responses
`define IC_RESP_OKAY 2'h0
`define IC_RESP_SLVERR 2'h2

// timing: quarter of a bus bit period
`define IC_CLK_NS 8
`define IC_QTR_NS 2500
`define IC_QTR_CYC ((`IC_QTR_NS + `IC_CLK_NS - 1) / `IC_CLK_NS)

`endif

//--- include/ic_pkg.sv
// types shared by the two-wire bus control block
// assumes ic_defs.svh is used for all numeric constants
package ic_pkg;

  // bus engine states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_SLAVE = 6'b000010,
    ST_START = 6'b000100,
    ST_HOLD  = 6'b001000,
    ST_BIT   = 6'b010000,
    ST_STOP  = 6'b100000
  } ic_state_t;

endpackage

//--- src/ic_ctrl.sv
// two-wire bus controller with control, status and event registers
// assumes an AXI4-Lite master and open-drain pads resolved outside
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "ic_defs.svh"
module ic_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // bus clock pin
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  // bus data pin
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  ic_pkg::ic_state_t state;
  logic aw_full, w_full, wr_do, wr_en, aw_hit, ar_hit;
  logic [7:0] aw_addr, w_data, rd_mux;
  logic w_lane;
  logic wr_ctrl, wr_stat, wr_data, wr_evt, wr_mask, wr_own;
  logic module_enable, interrupt_enable, master_select;
  logic direction_select, ack_control;
  logic [7:0] own_addr, data_tx, rx_byte, shift;
  logic [`IC_EV_W-1:0] evt, evt_mask;
  logic arbitration_lost_flag, interrupt_pending_flag;
  logic slave_rw_indication, addressed, tc, rx_ack, busy;
  logic start_req, stop_req, repeat_start_request_req, byte_go;
  logic lose_now, lose_arb, done_p, aas_p, mstate, arb_bit, expect_high;
  logic scl_s, sda_s, scl_q, sda_q;
  logic start_det, stop_det, scl_rise, scl_fall;
  logic scl_drive, sda_drive, addr_ph, tick;
  logic [1:0] phase;
  logic [3:0] bit_cnt;
  logic [8:0] qcnt;

  ////////////////////////////////////////////////////////////////////////
  // register bus: write side

  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign wr_do = aw_full && w_full;
  assign wr_en = wr_do && w_lane && aw_hit;

  // address and data holding, taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 8'h00;
      w_lane <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_do)
        aw_full <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      else if (wr_do)
        w_full <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IC_RESP_OKAY;
    end
    else if (wr_do)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= aw_hit ? `IC_RESP_OKAY : `IC_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // address decode
  assign aw_hit = (aw_addr <= `IC_ADDR_MASK) && (aw_addr[1:0] == 2'h0);
  assign ar_hit = (s_axi_araddr <= `IC_ADDR_MASK) && (s_axi_araddr[1:0] == 2'h0);
  assign wr_own = wr_en && (aw_addr == `IC_ADDR_OWN);
  assign wr_ctrl = wr_en && (aw_addr == `IC_ADDR_CTRL);
  assign wr_stat = wr_en && (aw_addr == `IC_ADDR_STAT);
  assign wr_data = wr_en && (aw_addr == `IC_ADDR_DATA);
  assign wr_evt = wr_en && (aw_addr == `IC_ADDR_EVT);
  assign wr_mask = wr_en && (aw_addr == `IC_ADDR_MASK);

  ////////////////////////////////////////////////////////////////////////
  // register bus: read side

  assign s_axi_arready = !s_axi_rvalid;

  // read value mux
  always_comb
  begin
    case (s_axi_araddr)
      `IC_ADDR_OWN: rd_mux = {own_addr[7:1], 1'b0};
      `IC_ADDR_CTRL: rd_mux = {module_enable, interrupt_enable, master_select,
                               direction_select, ack_control, 3'b000};
      `IC_ADDR_STAT: rd_mux = {tc, addressed, busy, arbitration_lost_flag, 1'b0,
                               slave_rw_indication, interrupt_pending_flag, rx_ack};
      `IC_ADDR_DATA: rd_mux = rx_byte;
      `IC_ADDR_EVT: rd_mux = {5'h00, evt};
      `IC_ADDR_MASK: rd_mux = {5'h00, evt_mask};
      default: rd_mux = 8'h00;
    endcase
  end

  // read data and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `IC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_mux};
      s_axi_rresp <= ar_hit ? `IC_RESP_OKAY : `IC_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // control register and its requests

  assign start_req = wr_ctrl && module_enable && w_data[`IC_CB_MS] && !master_select;
  assign stop_req = wr_ctrl && module_enable && !w_data[`IC_CB_MS] && master_select;
  assign repeat_start_request_req = wr_ctrl && module_enable && w_data[`IC_CB_RS];

  // control bits; writable even while disabled
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      module_enable <= 1'b0;
      interrupt_enable <= 1'b0;
      master_select <= 1'b0;
      direction_select <= 1'b0;
      ack_control <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        module_enable <= w_data[`IC_CB_EN];
        interrupt_enable <= w_data[`IC_CB_IE];
        master_select <= w_data[`IC_CB_MS];
        direction_select <= w_data[`IC_CB_DIR];
        ack_control <= w_data[`IC_CB_ACK];
      end
      if (lose_now)
        master_select <= 1'b0;
    end
  end

  // own address, transmit byte and pending byte request
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      own_addr <= `IC_OWN_RST;
      data_tx <= 8'h00;
      byte_go <= 1'b0;
    end
    else
    begin
      if (wr_data)
        byte_go <= 1'b1;
      else if (state != ic_pkg::ST_START && state != ic_pkg::ST_HOLD)
        byte_go <= 1'b0;
      if (wr_own)
        own_addr <= w_data;
      if (wr_data)
        data_tx <= w_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // events, status flags and interrupt

  assign interrupt_pending_flag = |(evt & evt_mask);
  assign irq = module_enable && interrupt_enable && interrupt_pending_flag;

  // sticky events, set wins over write-one clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      evt <= `IC_EVT_RST;
      evt_mask <= `IC_EVT_RST;
      arbitration_lost_flag <= 1'b0;
    end
    else
    begin
      if (wr_mask)
        evt_mask <= w_data[`IC_EV_W-1:0];
      evt <= (evt & ~(wr_evt ? w_data[`IC_EV_W-1:0] : `IC_EVT_RST))
             | {aas_p, lose_arb, done_p};
      if (lose_arb)
        arbitration_lost_flag <= 1'b1;
      else if (wr_stat && !w_data[`IC_SB_AL])
        arbitration_lost_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin sampling and bus condition detection

  ic_sync #(.WIDTH(2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({scl_i, sda_i}),
    .sync_out({scl_s, sda_s})
  );

  // delayed copies for edge detection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign start_det = scl_s && scl_q && sda_q && !sda_s;
  assign stop_det = scl_s && scl_q && !sda_q && sda_s;
  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;

  // bus busy; unknown to a freshly enabled module
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !module_enable)
      busy <= 1'b0;
    else if (start_det)
      busy <= 1'b1;
    else if (stop_det)
      busy <= 1'b0;
  end

  // quarter bit period enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn || qcnt == 9'(`IC_QTR_CYC - 1))
      qcnt <= 9'h000;
    else
      qcnt <= qcnt + 9'h001;
  end
  assign tick = (qcnt == 9'(`IC_QTR_CYC - 1));

  ////////////////////////////////////////////////////////////////////////
  // arbitration loss

  assign mstate = (state == ic_pkg::ST_START) || (state == ic_pkg::ST_HOLD)
                  || (state == ic_pkg::ST_BIT);
  assign expect_high = (bit_cnt < 4'h8) ? (direction_select && shift[7])
                       : (!direction_select && ack_control);
  assign arb_bit = (state == ic_pkg::ST_BIT) && tick && (phase == 2'h2) && scl_s
                   && expect_high && !sda_s;
  assign lose_now = module_enable && (arb_bit || (stop_det && mstate)
                    || (start_req && busy && !mstate)
                    || (repeat_start_request_req && !mstate));

  ////////////////////////////////////////////////////////////////////////
  // bus engine

  always_ff @(posedge aclk)
  begin
    lose_arb <= lose_now;
    done_p <= 1'b0;
    aas_p <= 1'b0;
    if (!aresetn || !module_enable)
    begin
      state <= ic_pkg::ST_IDLE;
      phase <= 2'h0;
      bit_cnt <= 4'h0;
      scl_drive <= 1'b0;
      sda_drive <= 1'b0;
      addr_ph <= 1'b0;
      addressed <= 1'b0;
      slave_rw_indication <= 1'b0;
      tc <= 1'b1;
      rx_ack <= 1'b1;
      rx_byte <= 8'h00;
      shift <= 8'h00;
    end
    else if (lose_now)
    begin
      state <= ic_pkg::ST_IDLE;
      scl_drive <= 1'b0;
      sda_drive <= 1'b0;
      phase <= 2'h0;
    end
    else
    begin
      if (wr_ctrl)
        addressed <= 1'b0;
      case (state)
        ic_pkg::ST_IDLE:
        begin
          if (start_req)
          begin
            state <= ic_pkg::ST_START;
            phase <= 2'h0;
          end
          else if (start_det)
          begin
            state <= ic_pkg::ST_SLAVE;
            bit_cnt <= 4'h0;
            addr_ph <= 1'b1;
          end
        end
        ic_pkg::ST_SLAVE:
        begin
          if (start_req)
          begin
            state <= ic_pkg::ST_START;
            phase <= 2'h0;
            sda_drive <= 1'b0;
          end
          else if (stop_det)
          begin
            state <= ic_pkg::ST_IDLE;
            sda_drive <= 1'b0;
          end
          else if (start_det)
          begin
            bit_cnt <= 4'h0;
            addr_ph <= 1'b1;
            sda_drive <= 1'b0;
          end
          else if (scl_rise)
          begin
            if (bit_cnt < 4'h8)
              shift <= {shift[6:0], sda_s};
            else if (!addr_ph && direction_select)
              rx_ack <= sda_s;
            if (bit_cnt == 4'h0)
              tc <= 1'b0;
          end
          else if (scl_fall)
          begin
            if (bit_cnt == 4'h7)
            begin
              bit_cnt <= 4'h8;
              if (addr_ph && shift[7:1] == own_addr[7:1])
              begin
                addressed <= 1'b1;
                aas_p <= 1'b1;
                slave_rw_indication <= shift[0];
                sda_drive <= 1'b1;
              end
              else if (addr_ph)
                state <= ic_pkg::ST_IDLE;
              else
                sda_drive <= direction_select ? 1'b0 : !ack_control;
            end
            else if (bit_cnt == 4'h8)
            begin
              bit_cnt <= 4'h0;
              addr_ph <= 1'b0;
              done_p <= 1'b1;
              tc <= 1'b1;
              rx_byte <= shift;
              shift <= data_tx;
              sda_drive <= direction_select && !data_tx[7];
            end
            else
            begin
              bit_cnt <= bit_cnt + 4'h1;
              sda_drive <= !addr_ph && direction_select && !shift[7];
            end
          end
        end
        ic_pkg::ST_START:
        begin
          if (tick)
          begin
            case (phase)
              2'h0: sda_drive <= 1'b0;
              2'h1: scl_drive <= 1'b0;
              2'h2: sda_drive <= scl_s;
              default: scl_drive <= 1'b1;
            endcase
            if (phase != 2'h2 || scl_s)
              phase <= phase + 2'h1;
            if (phase == 2'h3)
              state <= ic_pkg::ST_HOLD;
          end
        end
        ic_pkg::ST_HOLD:
        begin
          if (tick)
            sda_drive <= 1'b0; // data freed only after clock is low
          if (stop_req)
          begin
            state <= ic_pkg::ST_STOP;
            phase <= 2'h0;
          end
          else if (repeat_start_request_req)
          begin
            state <= ic_pkg::ST_START;
            phase <= 2'h0;
          end
          else if (byte_go)
          begin
            state <= ic_pkg::ST_BIT;
            phase <= 2'h0;
            bit_cnt <= 4'h0;
            shift <= data_tx;
            tc <= 1'b0;
          end
        end
        ic_pkg::ST_BIT:
        begin
          if (tick)
          begin
            case (phase)
              2'h0:
              begin
                if (bit_cnt < 4'h8)
                  sda_drive <= direction_select && !shift[7];
                else
                  sda_drive <= !direction_select && !ack_control;
              end
              2'h1: scl_drive <= 1'b0;
              2'h2:
              begin
                if (scl_s && bit_cnt < 4'h8)
                  shift <= {shift[6:0], sda_s};
                else if (scl_s && direction_select)
                  rx_ack <= sda_s;
              end
              default:
              begin
                scl_drive <= 1'b1;
                if (bit_cnt == 4'h8)
                begin
                  state <= ic_pkg::ST_HOLD;
                  bit_cnt <= 4'h0;
                  done_p <= 1'b1;
                  tc <= 1'b1;
                  rx_byte <= shift;
                end
                else
                  bit_cnt <= bit_cnt + 4'h1;
              end
            endcase
            if (phase != 2'h2 || scl_s)
              phase <= phase + 2'h1;
          end
        end
        ic_pkg::ST_STOP:
        begin
          if (tick)
          begin
            case (phase)
              2'h0: sda_drive <= 1'b1;
              2'h1: scl_drive <= 1'b0;
              2'h2: sda_drive <= !scl_s;
              default: state <= ic_pkg::ST_IDLE;
            endcase
            if (phase != 2'h2 || scl_s)
              phase <= phase + 2'h1;
          end
        end
        default:
        begin
          state <= ic_pkg::ST_IDLE;
          scl_drive <= 1'b0;
          sda_drive <= 1'b0;
        end
      endcase
    end
  end

  // open-drain pads: enable low pulls the line to zero
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = !scl_drive;
  assign sda_oe_n = !sda_drive;

endmodule // ic_ctrl

//--- src/ic_sync.sv
// two-flop synchroniser for asynchronous pin levels
// assumes idle-high lines, so both stages reset to one
`timescale 1ns/10ps
module ic_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // one pair of flops per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          stage1[i] <= 1'b1;
          sync_out[i] <= 1'b1;
        end
        else
        begin
          stage1[i] <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule // ic_sync

//--- tb/ic_ctrl_props.sv
// port checker for the two-wire bus control block
// sees only top-level ports; bound to every ic_ctrl
`timescale 1ns/10ps
`include "ic_defs.svh"
module ic_ctrl_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic scl_i,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic irq
);
  logic [7:0] aw_q, ar_q, wd_q, ctl_q, ctl_e;
  logic bv_q;
  // capture addresses and data at their handshakes
  always_ff @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
    if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
  end
  // control shadow, live from the cycle the write completes
  always_comb
  begin
    ctl_e = ctl_q;
    if (s_axi_bvalid && !bv_q && aw_q == `IC_ADDR_CTRL && s_axi_bresp == 2'h0) ctl_e = wd_q;
  end
  always_ff @(posedge aclk)
  begin
    bv_q <= aresetn && s_axi_bvalid;
    ctl_q <= aresetn ? ctl_e : 8'h00;
  end
  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_IRQ_GATED: assert property (irq |-> ctl_e[7] && ctl_e[6])
    else $error("irq high with enables clear");
  AST_OFF_QUIET: assert property (!ctl_e[7] [*3] |-> sda_oe_n && scl_oe_n)
    else $error("pin pulled while disabled");
  AST_START_MASTER: assert property ($fell(sda_oe_n) && scl_i |-> ctl_e[7] && ctl_e[5])
    else $error("start without master select");
  AST_STOP_CLEARED: assert property ($rose(sda_oe_n) && !$rose(scl_oe_n) && scl_i
    |-> !ctl_e[5] || !ctl_e[7])
    else $error("stop while master select set");
  AST_CTRL_READ: assert property (s_axi_rvalid && ar_q == `IC_ADDR_CTRL
    |-> s_axi_rdata[2:0] == 3'h0 && s_axi_rdata[31:8] == 24'h0)
    else $error("control read shows write-only bits");
  AST_B_AFTER_W: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata))
    else $error("read data dropped");
  // main scenarios
  cover property ($fell(sda_oe_n) && scl_i);
  cover property ($rose(sda_oe_n) && scl_i);
  cover property (irq);
endmodule // ic_ctrl_props

bind ic_ctrl ic_ctrl_props ic_ctrl_props_i (.*);

//--- tb/ic_slave_model.sv
// behavioural slave on the two-wire bus
// watches resolved lines; pulls sda low only through sda_oe_n
`timescale 1ns/10ps
module ic_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  // resolved lines
  input wire logic scl,
  input wire logic sda,
  // low pulls sda
  output logic sda_oe_n,
  // byte returned, last byte seen, last ack from master
  input wire logic [7:0] tx_byte,
  output logic [7:0] got_byte,
  output logic got_ack
);
  int bitn;
  logic [7:0] sh;
  logic act, rd, adr;
  initial
  begin
    sda_oe_n = 1'b1;
    act = 1'b0;
    rd = 1'b0;
    got_ack = 1'b1;
    got_byte = 8'h00;
  end
  // start and stop: sda moving while scl high
  always @(negedge sda)
  begin
    if (scl === 1'b1)
    begin
      act = 1'b1;
      adr = 1'b1;
      bitn = 0;
    end
  end
  always @(posedge sda)
    if (scl === 1'b1) act = 1'b0;
  // sample on scl rise, msb first
  always @(posedge scl)
  begin
    if (act && bitn < 8) sh = {sh[6:0], sda};
    else if (act && !adr && rd) got_ack = sda;
    bitn++;
  end
  // drive on scl fall: ack, data bit or release
  always @(negedge scl)
  begin
    if (bitn == 9)
    begin
      if (!adr && rd && got_ack) act = 1'b0;  // master refused more data
      adr = 1'b0;
      bitn = 0;
    end
    if (bitn == 8) got_byte = sh;
    if (bitn == 8 && adr) rd = sh[0];
    if (!act) sda_oe_n = 1'b1;
    else if (bitn == 8) sda_oe_n = adr ? (sh[7:1] != ADDR) : rd;
    else sda_oe_n = (rd && !adr) ? tx_byte[7 - bitn] : 1'b1;
  end
endmodule // ic_slave_model

//--- tb/test_ic_ctrl.sv
// self-checking bench for the two-wire bus control block
// register bus tasks; one slave model at address 0x2A
`timescale 1ns/10ps
`include "ic_defs.svh"
module test_ic_ctrl;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, sl_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, irq, sl_oe_n, sl_ack, scl_w, sda_w;
  int error_cnt, n_checks, cyc;
  // open-drain lines with pull-ups
  assign scl_w = scl_oe_n ? 1'b1 : scl_o;
  assign sda_w = (sda_oe_n ? 1'b1 : sda_o) & sl_oe_n;
  ic_ctrl ic_ctrl_i (.*, .scl_i(scl_w), .sda_i(sda_w));
  ic_slave_model ic_slave_model_i (.scl(scl_w), .sda(sda_w), .sda_oe_n(sl_oe_n),
    .tx_byte(8'hA5), .got_byte(sl_byte), .got_ack(sl_ack));
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // hang guard
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("errors=%0d checks=%0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write one register; bready raised late on purpose
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
    logic ah, wh;
    ah = 1'b0;
    wh = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ah && wh))
    begin
      @(posedge aclk);
      ah = ah || s_axi_awready;
      wh = wh || s_axi_wready;
      s_axi_awvalid <= !ah;
      s_axi_wvalid <= !wh;
    end
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat (2) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask
  // poll a status bit until it reaches a level
  task automatic wait_bit(input logic [7:0] a, input int b, input logic val);
    int n;
    n = 0;
    do
    begin
      rd(a, v);
      n++;
    end
    while (v[b] !== val && n < 5000);
    chk({31'h0, v[b]}, {31'h0, val});
  endtask
  // one byte on the bus, then clear its event
  task automatic xfer(input logic [7:0] d);
    wr(`IC_ADDR_DATA, d);
    wait_bit(`IC_ADDR_EVT, 0, 1'b1);
    wr(`IC_ADDR_EVT, 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`IC_ADDR_CTRL, v);
    chk(v, 32'h00);
    rd(`IC_ADDR_STAT, v);
    chk(v, 32'h81);
    // disabled: bits stored but inert
    wr(`IC_ADDR_CTRL, 8'h7F);
    rd(`IC_ADDR_CTRL, v);
    chk(v, 32'h78);
    rd(`IC_ADDR_STAT, v);
    chk(v, 32'h81);
    // repeat start while not master
    wr(`IC_ADDR_CTRL, 8'h80);
    wr(`IC_ADDR_CTRL, 8'h84);
    rd(`IC_ADDR_CTRL, v);
    chk(v, 32'h80);
    rd(`IC_ADDR_STAT, v);
    chk(v & 32'h12, 32'h10);
    // interrupt raise, gate, mask, clear
    wr(`IC_ADDR_MASK, 8'h02);
    chk({31'h0, irq}, 32'h0);
    wr(`IC_ADDR_CTRL, 8'hC0);
    chk({31'h0, irq}, 32'h1);
    wr(`IC_ADDR_CTRL, 8'h40);
    chk({31'h0, irq}, 32'h0);
    wr(`IC_ADDR_CTRL, 8'h80);
    chk({31'h0, irq}, 32'h0);
    rd(`IC_ADDR_STAT, v);
    chk(v & 32'h12, 32'h12);
    wr(`IC_ADDR_STAT, 8'h00);
    rd(`IC_ADDR_STAT, v);
    chk(v & 32'h10, 32'h0);
    wr(`IC_ADDR_EVT, 8'h02);
    wr(`IC_ADDR_MASK, 8'h00);
    wr(8'h18, 8'hFF, 2'h2);
    rd(8'h18, v, 2'h2);
    chk(v, 32'h0);
    // master read of one acked and one refused byte
    wr(`IC_ADDR_CTRL, 8'hB0);
    xfer(8'h55);
    chk({24'h0, sl_byte}, 32'h55);
    wr(`IC_ADDR_CTRL, 8'hA0);
    xfer(8'h00);
    rd(`IC_ADDR_DATA, v);
    chk(v, 32'hA5);
    chk({31'h0, sl_ack}, 32'h0);
    wr(`IC_ADDR_CTRL, 8'hA8);
    xfer(8'h00);
    chk({31'h0, sl_ack}, 32'h1);
    wr(`IC_ADDR_CTRL, 8'h88);
    wait_bit(`IC_ADDR_STAT, 5, 1'b0);
    chk({30'h0, scl_w, sda_w}, 32'h3);
    rd(`IC_ADDR_STAT, v);
    chk(v & 32'h10, 32'h0);
    complete_run();
  end
endmodule // test_ic_ctrl
